// [verilog/sih_pkg.sv]
// constants, states and carriers of the serial interrupt host controller
`default_nettype none
package sih_pkg;
    // =========================================================
    // frame timing
    localparam int unsigned FRAME_COUNT = 17;
    localparam logic [2:0] HOLD_MIN = 3'h3;
    localparam logic [2:0] HOLD_MAX = 3'h7;
    localparam logic [3:0] STOP_QUIET_LEN = 4'h2;
    localparam logic [3:0] STOP_CONT_LEN = 4'h3;
    localparam logic [1:0] PH_SAMPLE = 2'h0;
    localparam logic [1:0] PH_RECOVER = 2'h1;
    localparam logic [1:0] PH_TURN = 2'h2;
    localparam logic [4:0] FIRST_IRQ_FRAME = 5'h02;
    localparam logic [4:0] LAST_IRQ_FRAME = 5'h10;
    localparam logic [15:0] IRQ_DEFAULT = 16'hFFFF;
    localparam logic MODE_CONT = 1'b1;
    localparam logic MODE_QUIET = 1'b0;

    // =========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_LO,
        ST_START_HI,
        ST_DATA,
        ST_STOP_LO,
        ST_STOP_HI,
        ST_STOP_TA
    } sih_state_t;

    typedef struct packed {
        logic quiet_next; // stop width selects quiet mode for the next cycle
        logic cont_run;   // start a new cycle after every stop in continuous mode
        logic start_req;  // one-cycle request to run a cycle
        logic [2:0] start_hold;
    } sih_ctl_t;

    typedef struct packed {
        logic busy;
        logic mode_cont;
        logic cycle_done;
    } sih_stat_t;
endpackage : sih_pkg
`default_nettype wire

// [verilog/sih_host.sv]
// host controller of the one-wire serial interrupt line
`default_nettype none
module sih_host #(
    parameter int unsigned FRAMES = sih_pkg::FRAME_COUNT
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // control from the interrupt controller
    input wire sih_pkg::sih_ctl_t ctl_i,
    // serial interrupt line, open drain
    input wire logic serial_interrupt_line_i,
    output logic serial_interrupt_line_o,
    output logic serial_interrupt_line_oe_o,
    // collected levels and status
    output logic [15:0] irq_level_o,
    output sih_pkg::sih_stat_t stat_o
);
    // =========================================================
    // state
    sih_pkg::sih_state_t st_r;
    logic [3:0] cnt_r;
    logic [4:0] fr_r;
    logic [1:0] ph_r;
    logic mode_r;
    logic stop_quiet_r;
    logic [15:0] irq_r;
    logic done_r;
    logic drv_o_r;
    logic drv_oe_r;
    logic busy_r;
    logic [4:0] last_frame;

    assign last_frame = 5'(FRAMES);

    // hold time clamped into the legal three to seven clocks
    function automatic logic [3:0] hold_len(input logic [2:0] h);
        logic [2:0] v;
        v = (h < sih_pkg::HOLD_MIN) ? sih_pkg::HOLD_MIN : h;
        return {1'b0, v};
    endfunction

    // =========================================================
    // cycle sequencer and line drive
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r <= sih_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            fr_r <= 5'h00;
            ph_r <= sih_pkg::PH_TURN;
            stop_quiet_r <= 1'b0;
            drv_o_r <= 1'b1;
            drv_oe_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            case (st_r)
                sih_pkg::ST_IDLE: begin
                    if (ctl_i.start_req || (mode_r == sih_pkg::MODE_CONT && ctl_i.cont_run)) begin
                        // host start: one own low clock plus the hold
                        st_r <= sih_pkg::ST_START_LO;
                        cnt_r <= hold_len(ctl_i.start_hold) + 4'h1;
                        busy_r <= 1'b1;
                        drv_o_r <= 1'b0;
                        drv_oe_r <= 1'b1;
                    end else if (mode_r == sih_pkg::MODE_QUIET && !serial_interrupt_line_i) begin
                        // a slave began the start; take over next clock
                        st_r <= sih_pkg::ST_START_LO;
                        cnt_r <= hold_len(ctl_i.start_hold);
                        busy_r <= 1'b1;
                        drv_o_r <= 1'b0;
                        drv_oe_r <= 1'b1;
                    end
                end
                sih_pkg::ST_START_LO: begin
                    if (cnt_r <= 4'h1) begin
                        st_r <= sih_pkg::ST_START_HI;
                        drv_o_r <= 1'b1;
                    end
                    cnt_r <= cnt_r - 4'h1;
                end
                sih_pkg::ST_START_HI: begin
                    // rising edge seen; frame 0 turn-around follows
                    st_r <= sih_pkg::ST_DATA;
                    drv_oe_r <= 1'b0;
                    fr_r <= 5'h00;
                    ph_r <= sih_pkg::PH_TURN;
                end
                sih_pkg::ST_DATA: begin
                    if (ph_r == sih_pkg::PH_TURN) begin
                        ph_r <= sih_pkg::PH_SAMPLE;
                        fr_r <= fr_r + 5'h01;
                    end else begin
                        ph_r <= ph_r + 2'h1;
                    end
                    if (ph_r == sih_pkg::PH_TURN && fr_r == last_frame) begin
                        // all frames done; stop width carries next mode
                        st_r <= sih_pkg::ST_STOP_LO;
                        stop_quiet_r <= ctl_i.quiet_next;
                        cnt_r <= ctl_i.quiet_next ? sih_pkg::STOP_QUIET_LEN
                                                  : sih_pkg::STOP_CONT_LEN;
                        drv_o_r <= 1'b0;
                        drv_oe_r <= 1'b1;
                    end
                end
                sih_pkg::ST_STOP_LO: begin
                    if (cnt_r <= 4'h1) begin
                        st_r <= sih_pkg::ST_STOP_HI;
                        drv_o_r <= 1'b1;
                    end
                    cnt_r <= cnt_r - 4'h1;
                end
                sih_pkg::ST_STOP_HI: begin
                    st_r <= sih_pkg::ST_STOP_TA;
                    drv_oe_r <= 1'b0;
                end
                sih_pkg::ST_STOP_TA: begin
                    // earliest next start is the clock after this one
                    st_r <= sih_pkg::ST_IDLE;
                    busy_r <= 1'b0;
                end
                default: begin
                    st_r <= sih_pkg::ST_IDLE;
                    drv_oe_r <= 1'b0;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // mode taken over only inside the stop frame
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mode_r <= sih_pkg::MODE_CONT;
        end else if (st_r == sih_pkg::ST_STOP_HI) begin
            mode_r <= stop_quiet_r ? sih_pkg::MODE_QUIET : sih_pkg::MODE_CONT;
        end
    end

    // =========================================================
    // level capture in the sample phase of frames 2 to 16
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_r <= sih_pkg::IRQ_DEFAULT;
        end else if (st_r == sih_pkg::ST_DATA && ph_r == sih_pkg::PH_SAMPLE &&
                     fr_r >= sih_pkg::FIRST_IRQ_FRAME && fr_r <= sih_pkg::LAST_IRQ_FRAME) begin
            irq_r[4'(fr_r - 5'h01)] <= serial_interrupt_line_i;
        end
    end

    // end of data pulse
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (st_r == sih_pkg::ST_DATA && ph_r == sih_pkg::PH_TURN &&
                       fr_r == last_frame);
        end
    end

    // outputs straight from flops
    assign serial_interrupt_line_o = drv_o_r;
    assign serial_interrupt_line_oe_o = drv_oe_r;
    assign irq_level_o = irq_r;
    assign stat_o = '{busy: busy_r, mode_cont: mode_r, cycle_done: done_r};

    // =========================================================
    // checks
    a_reset_release: assert property (@(posedge clk_sys_i)
        sys_rst_i |=> !serial_interrupt_line_oe_o)
        else $error("line driven after reset");
    a_start_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r == sih_pkg::ST_IDLE && ctl_i.start_req) |=>
        (serial_interrupt_line_oe_o && !serial_interrupt_line_o)[*4])
        else $error("host start low shorter than four clocks");
    a_start_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r == sih_pkg::ST_START_HI) |->
        (serial_interrupt_line_oe_o && serial_interrupt_line_o) ##1 !serial_interrupt_line_oe_o)
        else $error("start not ended by one high clock and release");
    a_stop_quiet: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($rose(st_r == sih_pkg::ST_STOP_LO) && stop_quiet_r) |->
        !serial_interrupt_line_o ##1 !serial_interrupt_line_o ##1 serial_interrupt_line_o)
        else $error("quiet stop not two clocks low");
    a_stop_cont: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($rose(st_r == sih_pkg::ST_STOP_LO) && !stop_quiet_r) |->
        (!serial_interrupt_line_o)[*3] ##1 serial_interrupt_line_o)
        else $error("continuous stop not three clocks low");
    a_mode_in_stop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $changed(mode_r) |-> $past(st_r == sih_pkg::ST_STOP_HI))
        else $error("mode changed outside stop frame");
    a_cont_passive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r == sih_pkg::ST_IDLE && mode_r == sih_pkg::MODE_CONT && !ctl_i.start_req &&
         !ctl_i.cont_run) |=> st_r == sih_pkg::ST_IDLE)
        else $error("slave start honoured in continuous mode");
    a_stop_gap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r == sih_pkg::ST_STOP_HI) |=> !serial_interrupt_line_oe_o ##1 !serial_interrupt_line_oe_o)
        else $error("start began before second clock after stop");
    a_irq13_slot: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r == sih_pkg::ST_DATA && fr_r == 5'h0E && ph_r == sih_pkg::PH_SAMPLE) |=>
        irq_level_o[13] == $past(serial_interrupt_line_i))
        else $error("frame 14 not stored as level 13");
    a_cycle_span: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(st_r == sih_pkg::ST_START_HI) |-> ##53 (st_r == sih_pkg::ST_STOP_LO))
        else $error("data frames not 3N-1 aligned over seventeen frames");
endmodule : sih_host
`default_nettype wire

// [tb/sih_slave_model.sv]
// behavioural serial interrupt slave facing the host controller
`default_nettype none
module sih_slave_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // device side: enable, change request and levels (bit n = IRQn)
    input wire logic enable_i,
    input wire logic quiet_start_i,
    input wire logic [15:0] irq_i,
    // serial interrupt line
    input wire logic line_i,
    output logic drive_o,
    output logic drive_val_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_r;
    logic [6:0] cnt_r;
    logic [2:0] low_r;
    logic mode_cont_r;
    logic start_r;
    logic line_q_r;
    logic [4:0] frame;
    logic [1:0] ph;
    logic slot_low;

    // =========================================================
    // frame position and slot drive
    assign frame = 5'((cnt_r + 7'h01) / 7'h03);
    assign ph = 2'((cnt_r + 7'h01) % 7'h03);
    assign slot_low = (phase_r == 2'h2) && (frame >= 5'h02) && (frame <= 5'h10)
        && !irq_i[4'(frame - 5'h01)];
    assign drive_o = !sys_rst_i && enable_i && (start_r || (slot_low && ph != 2'h2));
    assign drive_val_o = !start_r && (ph == 2'h1);

    // =========================================================
    // cycle tracking, stop width and quiet start
    always_ff @(posedge clk_sys_i) begin
        line_q_r <= line_i;
        if (sys_rst_i) begin
            phase_r <= 2'h0;
            cnt_r <= 7'h00;
            low_r <= 3'h0;
            mode_cont_r <= 1'b1;
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (phase_r)
                2'h0: begin
                    if (!line_i) begin
                        phase_r <= 2'h1;
                    end else if (line_q_r && enable_i && !mode_cont_r && quiet_start_i) begin
                        start_r <= 1'b1;
                    end
                end
                2'h1: begin
                    if (line_i) begin
                        phase_r <= 2'h2;
                        cnt_r <= 7'h01;
                    end
                end
                2'h2: begin
                    cnt_r <= cnt_r + 7'h01;
                    if (cnt_r == 7'h34) begin
                        phase_r <= 2'h3;
                        low_r <= 3'h0;
                    end
                end
                default: begin
                    if (!line_i) begin
                        low_r <= low_r + 3'h1;
                    end else if (low_r != 3'h0) begin
                        mode_cont_r <= (low_r == 3'h3);
                        phase_r <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule // sih_slave_model
`default_nettype wire

// [tb/sih_host_bench.sv]
// self-checking bench of the serial interrupt host controller
`default_nettype none
module sih_host_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    sih_pkg::sih_ctl_t ctl = '0;
    logic enable = 1'b1;
    logic quiet_start = 1'b0;
    logic [15:0] levels = 16'hFFFF;
    logic line;
    logic host_line;
    logic rogue_low = 1'b0;
    logic host_val;
    logic host_oe;
    logic sl_drv;
    logic sl_val;
    logic [15:0] irq_level;
    sih_pkg::sih_stat_t stat;
    int errors = 0;
    int checks = 0;

    // =========================================================
    // clock, open line with pull-up, instances
    always #50 clk_sys_i = ~clk_sys_i;
    assign line = !((host_oe && !host_val) || (sl_drv && !sl_val));
    // stray low pulse that only the host sees, to test its refusal
    assign host_line = line && !rogue_low;
    sih_host i_sih_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ctl_i(ctl),
        .serial_interrupt_line_i(host_line), .serial_interrupt_line_o(host_val),
        .serial_interrupt_line_oe_o(host_oe), .irq_level_o(irq_level), .stat_o(stat));
    sih_slave_model i_sih_slave_model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .enable_i(enable), .quiet_start_i(quiet_start), .irq_i(levels), .line_i(line),
        .drive_o(sl_drv), .drive_val_o(sl_val));

    // =========================================================
    // compare, verdict and one full serial cycle
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic run_cycle(input logic by_slave, input logic quiet_nxt, input logic [2:0] hold,
            input logic [15:0] lv, input logic [15:0] exp_irq, input logic [3:0] exp_low);
        int n;
        int low;
        int done;
        n = 0;
        low = 0;
        done = 0;
        levels = lv;
        ctl.quiet_next = quiet_nxt;
        ctl.start_hold = hold;
        quiet_start = by_slave;
        ctl.start_req = !by_slave;
        @(negedge clk_sys_i);
        quiet_start = 1'b0;
        ctl.start_req = 1'b0;
        while (line !== 1'b0 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        while (line === 1'b0 && low < 15) begin
            @(negedge clk_sys_i);
            low++;
        end
        chk(16'(low), {12'h000, exp_low});
        while (stat.busy !== 1'b0 && n < 300) begin
            @(negedge clk_sys_i);
            n++;
            if (stat.cycle_done === 1'b1) begin
                done++;
            end
        end
        chk(16'(done), 16'h0001);
        chk(irq_level, exp_irq);
        chk({15'h0000, stat.mode_cont}, {15'h0000, !quiet_nxt});
    endtask

    // =========================================================
    // scenarios
    task automatic test_reset();
        repeat (8) @(negedge clk_sys_i);
        chk({15'h0000, host_oe}, 16'h0000);
        sys_rst_i = 1'b0;
        @(negedge clk_sys_i);
        chk(irq_level, 16'hFFFF);
        chk({15'h0000, stat.mode_cont}, 16'h0001);
    endtask
    task automatic test_cont_passive();
        int low;
        low = 0;
        quiet_start = 1'b1;
        repeat (20) begin
            @(negedge clk_sys_i);
            if (line === 1'b0) begin
                low++;
            end
        end
        quiet_start = 1'b0;
        chk(16'(low), 16'h0000);
        // a low clock in continuous mode must not start a cycle
        rogue_low = 1'b1;
        @(negedge clk_sys_i);
        rogue_low = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk({15'h0000, stat.busy}, 16'h0000);
        chk({15'h0000, host_oe}, 16'h0000);
    endtask
    task automatic test_host_irq13();
        run_cycle(1'b0, 1'b0, 3'h5, 16'hDFFF, 16'hDFFF, 4'h6);
    endtask
    task automatic test_quiet_stop();
        run_cycle(1'b0, 1'b1, 3'h0, 16'hA5A4, 16'hA5A5, 4'h4);
    endtask
    task automatic test_slave_start();
        run_cycle(1'b1, 1'b0, 3'h7, 16'h7FFE, 16'h7FFF, 4'h8);
    endtask
    task automatic test_disabled();
        enable = 1'b0;
        run_cycle(1'b0, 1'b0, 3'h3, 16'h0000, 16'hFFFF, 4'h4);
        enable = 1'b1;
    endtask
    task automatic test_cont_run();
        ctl.cont_run = 1'b1;
        run_cycle(1'b1, 1'b0, 3'h3, 16'hFFF7, 16'hFFF7, 4'h4);
        ctl.cont_run = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk({15'h0000, stat.busy}, 16'h0000);
    endtask

    // =========================================================
    // main sequence and watchdog
    initial begin
        test_reset();
        test_host_irq13();
        test_cont_passive();
        test_quiet_stop();
        test_slave_start();
        test_disabled();
        test_cont_run();
        results();
    end
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        errors++;
        results();
    end
endmodule // sih_host_bench
`default_nettype wire
